// ---- dasup_pkg.sv ----
// Package with constants, types and register map of the drive alarm supervisor
package dasup_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ALARM = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_FOLLOW = 8'h0c;
    localparam logic [7:0] OFF_TEMP = 8'h10;
    localparam logic [7:0] OFF_MEAS = 8'h14;
    localparam logic [7:0] OFF_SPEED = 8'h18;
    localparam logic [7:0] OFF_VOLT = 8'h1c;

    // Control field positions
    localparam int CTRL_CFG_LSB = 0;
    localparam int CTRL_HIGHV = 3;
    localparam int CTRL_THERMO = 4;
    localparam int CTRL_CLEAR = 5;
    localparam int CTRL_CANSD = 6;
    localparam int CTRL_POLE_LSB = 8;

    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] FOLLOW_RESET = 16'h0028;
    localparam logic [7:0] TEMP_RESET = 8'h50;

    // Bus voltage thresholds in volts
    localparam logic [7:0] OVERV_LOW_V = 8'd80;
    localparam logic [7:0] OVERV_HIGH_V = 8'd122;
    localparam logic [7:0] UNDERV_V = 8'd12;

    // Speed following band in percent
    localparam logic [7:0] FOLLOW_LO_PCT = 8'd80;
    localparam logic [7:0] FOLLOW_HI_PCT = 8'd120;

    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int STALL_MS = 1000;
    localparam int STALL_CYC = CLK_HZ / 1000 * STALL_MS;
    localparam int TICK_MS = 10;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int BLINK_MS = 500;
    localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;

    // Operating configurations
    typedef enum logic [2:0] {
        DASUP_CFG_NONE,
        DASUP_CFG_STANDALONE,
        DASUP_CFG_PLC,
        DASUP_CFG_EV,
        DASUP_CFG_CAN,
        DASUP_CFG_SERIAL,
        DASUP_CFG_STEERING,
        DASUP_CFG_RSVD
    } dasup_cfg_t;

    // LED colour codes
    localparam logic [1:0] LED_OFF = 2'd0;
    localparam logic [1:0] LED_GREEN = 2'd1;
    localparam logic [1:0] LED_ORANGE = 2'd2;
    localparam logic [1:0] LED_RED = 2'd3;

    // Relay and brake status codes
    localparam logic [1:0] RELAY_DISABLED = 2'd0;
    localparam logic [1:0] RELAY_ENABLED = 2'd1;
    localparam logic [1:0] RELAY_FAILED = 2'd2;
    localparam logic [1:0] BRAKE_UNLOCKED = 2'd0;
    localparam logic [1:0] BRAKE_LOCKED = 2'd1;
    localparam logic [1:0] BRAKE_FAILED = 2'd2;

    // Alarm bit positions
    localparam int AL_CONFIG = 0;
    localparam int AL_FOLLOW = 1;
    localparam int AL_DRVTEMP = 2;
    localparam int AL_COMM = 3;
    localparam int AL_FEEDBACK = 4;
    localparam int AL_OVERCUR = 5;
    localparam int AL_EMERG = 6;
    localparam int AL_OVERV = 7;
    localparam int AL_SETPT = 8;
    localparam int AL_ANALOG = 9;
    localparam int AL_MOTTEMP = 10;
    localparam int AL_SAFETY = 11;
    localparam int AL_STALL = 12;
    localparam int AL_OTHER = 13;
    localparam int AL_N = 14;

    // Condition inputs grouped
    typedef struct packed {
        logic motor_running;
        logic speed_valid;
        logic [15:0] speed;
        logic [15:0] setpoint;
        logic [7:0] drive_temp;
        logic [7:0] motor_temp;
        logic motor_sensor_open;
        logic [7:0] bus_volt;
        logic [2:0] phase_overcur;
        logic feedback_fault;
        logic comm_timeout;
        logic emergency_ok;
        logic safety_ok;
        logic pot_nonzero;
        logic analog_open;
        logic motor_blocked;
        logic current_high;
        logic nvm_programmed;
        logic supply_reversed;
        logic relay_fault;
        logic brake_fault;
        logic reset_pin;
        logic cw_limit;
        logic ccw_limit;
        logic can_switch_on_disabled;
        logic can_fault_reset;
    } dasup_cond_t;

    // Whole state of the supervisor
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] follow_ticks;
        logic [7:0] max_drive_temp;
        logic [7:0] max_motor_temp;
        logic [AL_N-1:0] alarm;
        logic reversal;
        logic reset_pin_d;
        logic started;
        logic [15:0] follow_cnt;
        logic [23:0] tick_cnt;
        logic [25:0] stall_cnt;
        logic [24:0] blink_cnt;
        logic blink;
        logic sd_seen;
        logic [1:0] led;
        logic relay_en;
        logic bridge_en;
        logic brake_lock;
        logic [1:0] relay_stat;
        logic [1:0] brake_stat;
        logic cw_ind;
        logic ccw_ind;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } dasup_state_t;

endpackage

// ---- dasup_top.sv ----
// Drive alarm supervisor: alarm latching, shutdown, LED and status logic
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
module dasup_top
    import dasup_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic CE,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    // Conditions
    input wire dasup_cond_t COND,
    // Drive outputs
    output logic RELAY_EN,
    output logic BRIDGE_EN,
    output logic BRAKE_LOCK,
    output logic [1:0] LED,
    output logic [1:0] RELAY_STAT,
    output logic [1:0] BRAKE_STAT,
    output logic REVERSAL,
    output logic CLOCKWISE_TRAVEL_LIMIT,
    output logic COUNTERCLOCKWISE_TRAVEL_LIMIT,
    output logic [AL_N-1:0] ALARM
);

    dasup_state_t r;
    dasup_state_t next_r;
    dasup_cfg_t cfg;
    logic [AL_N-1:0] cause;
    logic [23:0] spd_lo;
    logic [23:0] spd_hi;
    logic [23:0] spd_x;
    logic out_band;
    logic any_alarm;
    logic travel;
    logic clear_ev;
    logic wr;
    logic rd;
    logic [3:0] pole;

    assign cfg = dasup_cfg_t'(r.ctrl[CTRL_CFG_LSB +: 3]);
    assign pole = r.ctrl[CTRL_POLE_LSB +: 4];
    assign wr = PSEL && PENABLE && PWRITE && !r.pready;
    assign rd = PSEL && PENABLE && !PWRITE && !r.pready;
    assign spd_x = {COND.speed, 8'h00} / 24'd100;
    assign spd_lo = 24'(COND.setpoint) * 24'(FOLLOW_LO_PCT);
    assign spd_hi = 24'(COND.setpoint) * 24'(FOLLOW_HI_PCT);
    // Speed times 100 compared with setpoint times percent
    assign out_band = (24'(COND.speed) * 24'd100 < spd_lo)
                   || (24'(COND.speed) * 24'd100 > spd_hi);
    assign travel = COND.cw_limit || COND.ccw_limit;

    always_comb
    begin
        cause = '0;
        cause[AL_CONFIG] = (cfg == DASUP_CFG_NONE) || (cfg == DASUP_CFG_RSVD)
                        || pole == 4'h0 || pole[0] || !COND.nvm_programmed;
        cause[AL_FOLLOW] = out_band && r.follow_cnt >= r.follow_ticks
                        && r.follow_ticks != 16'h0000;
        cause[AL_DRVTEMP] = COND.drive_temp > r.max_drive_temp;
        cause[AL_COMM] = (cfg == DASUP_CFG_STEERING) && COND.comm_timeout;
        cause[AL_FEEDBACK] = COND.feedback_fault;
        cause[AL_OVERCUR] = |COND.phase_overcur;
        cause[AL_EMERG] = !COND.emergency_ok && (cfg == DASUP_CFG_STANDALONE
                        || cfg == DASUP_CFG_PLC || cfg == DASUP_CFG_EV
                        || cfg == DASUP_CFG_SERIAL);
        cause[AL_OVERV] = COND.bus_volt > (r.ctrl[CTRL_HIGHV] ? OVERV_HIGH_V
                                                            : OVERV_LOW_V);
        cause[AL_SETPT] = (cfg == DASUP_CFG_STANDALONE) && !r.started
                        && COND.pot_nonzero;
        cause[AL_ANALOG] = COND.analog_open && (cfg == DASUP_CFG_PLC
                        || cfg == DASUP_CFG_STANDALONE);
        cause[AL_MOTTEMP] = r.ctrl[CTRL_THERMO] ? COND.motor_sensor_open
                          : COND.motor_temp > r.max_motor_temp;
        cause[AL_SAFETY] = !COND.safety_ok;
        cause[AL_STALL] = r.stall_cnt >= 26'(STALL_CYC - 1)
                        && COND.motor_blocked && COND.current_high;
        cause[AL_OTHER] = COND.bus_volt < UNDERV_V;
    end

    assign clear_ev = (COND.reset_pin && !r.reset_pin_d && (cfg == DASUP_CFG_STANDALONE
                    || cfg == DASUP_CFG_EV || cfg == DASUP_CFG_PLC))
                    || COND.can_fault_reset
                    || (wr && PADDR == OFF_CTRL && PWDATA[CTRL_CLEAR]);

    always_comb
    begin
        next_r = r;
        next_r.reset_pin_d = COND.reset_pin;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        if (PSEL && PENABLE && !r.pready)
        begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0000_0000;
            case (PADDR)
                OFF_CTRL: next_r.prdata = r.ctrl;
                OFF_ALARM: next_r.prdata = 32'(r.alarm);
                OFF_STAT: next_r.prdata = {20'h00000, r.sd_seen, r.ccw_ind, r.cw_ind,
                    r.reversal, r.brake_stat, r.relay_stat, r.led, r.bridge_en,
                    r.relay_en};
                OFF_FOLLOW: next_r.prdata = {16'h0000, r.follow_ticks};
                OFF_TEMP: next_r.prdata = {16'h0000, r.max_motor_temp,
                    r.max_drive_temp};
                OFF_MEAS: next_r.prdata = {8'h00, COND.motor_temp, COND.drive_temp,
                    COND.bus_volt};
                OFF_SPEED: next_r.prdata = {COND.setpoint, COND.speed};
                OFF_VOLT: next_r.prdata = {24'h000000, spd_x[7:0]};
                default: next_r.pslverr = 1'b1;
            endcase
        end
        if (wr)
        begin
            case (PADDR)
                OFF_CTRL: next_r.ctrl = PWDATA & ~(32'h1 << CTRL_CLEAR);
                OFF_FOLLOW: next_r.follow_ticks = PWDATA[15:0];
                OFF_TEMP:
                begin
                    next_r.max_drive_temp = PWDATA[7:0];
                    next_r.max_motor_temp = PWDATA[15:8];
                end
                default: next_r.ctrl = r.ctrl;
            endcase
        end
        // Following timer in ticks of ten milliseconds
        if (r.tick_cnt >= 24'(TICK_CYC - 1))
            next_r.tick_cnt = 24'h000000;
        else
            next_r.tick_cnt = r.tick_cnt + 24'h000001;
        if (!out_band || !COND.motor_running)
            next_r.follow_cnt = 16'h0000;
        else if (r.tick_cnt == 24'h000000 && r.follow_cnt != 16'hffff)
            next_r.follow_cnt = r.follow_cnt + 16'h0001;
        if (COND.motor_blocked && COND.current_high)
        begin
            if (r.stall_cnt < 26'(STALL_CYC - 1))
                next_r.stall_cnt = r.stall_cnt + 26'h0000001;
        end
        else
            next_r.stall_cnt = '0;
        if (COND.motor_running)
            next_r.started = 1'b1;
        // Latch alarms; a new cause wins over a clear
        if (clear_ev)
            next_r.alarm = cause;
        else
            next_r.alarm = r.alarm | cause;
        if (COND.supply_reversed)
            next_r.reversal = 1'b1;
        // Fieldbus switch-on-disabled holds until shutdown is seen
        if (cfg != DASUP_CFG_CAN || !COND.can_switch_on_disabled)
            next_r.sd_seen = 1'b0;
        else if (r.ctrl[CTRL_CANSD])
            next_r.sd_seen = 1'b1;
        if (r.blink_cnt >= 25'(BLINK_CYC - 1))
        begin
            next_r.blink_cnt = '0;
            next_r.blink = !r.blink;
        end
        else
            next_r.blink_cnt = r.blink_cnt + 25'h0000001;
        if (cfg == DASUP_CFG_CAN && COND.can_switch_on_disabled && !r.sd_seen)
            next_r.led = LED_ORANGE;
        else if (any_alarm)
            next_r.led = LED_RED;
        else if (COND.motor_running)
            next_r.led = r.blink ? LED_GREEN : LED_OFF;
        else
            next_r.led = r.blink ? LED_ORANGE : LED_OFF;
        next_r.relay_en = !any_alarm && !travel;
        next_r.bridge_en = !any_alarm && !travel;
        next_r.brake_lock = 1'b0;
        next_r.cw_ind = COND.cw_limit;
        next_r.ccw_ind = COND.ccw_limit;
        next_r.relay_stat = COND.relay_fault ? RELAY_FAILED
                          : (next_r.relay_en ? RELAY_ENABLED : RELAY_DISABLED);
        next_r.brake_stat = COND.brake_fault ? BRAKE_FAILED
                          : (next_r.brake_lock ? BRAKE_LOCKED : BRAKE_UNLOCKED);
    end

    assign any_alarm = |(r.alarm | cause);

    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            r <= '0;
            r.ctrl <= CTRL_RESET;
            r.follow_ticks <= FOLLOW_RESET;
            r.max_drive_temp <= TEMP_RESET;
            r.max_motor_temp <= TEMP_RESET;
            r.led <= LED_OFF;
        end
        else if (CE)
            r <= next_r;
    end

    assign PREADY = r.pready;
    assign PRDATA = r.prdata;
    assign PSLVERR = r.pslverr;
    assign RELAY_EN = r.relay_en;
    assign BRIDGE_EN = r.bridge_en;
    assign BRAKE_LOCK = r.brake_lock;
    assign LED = r.led;
    assign RELAY_STAT = r.relay_stat;
    assign BRAKE_STAT = r.brake_stat;
    assign REVERSAL = r.reversal;
    assign CLOCKWISE_TRAVEL_LIMIT = r.cw_ind;
    assign COUNTERCLOCKWISE_TRAVEL_LIMIT = r.ccw_ind;
    assign ALARM = r.alarm;

    a_alarm_red: assert property (@(posedge CLOCK) disable iff (!RSTN)
        CE && |r.alarm && !(cfg == DASUP_CFG_CAN && COND.can_switch_on_disabled)
        |=> LED == LED_RED || !CE) else $error("alarm without red led");
    a_alarm_stop: assert property (@(posedge CLOCK) disable iff (!RSTN)
        |r.alarm && CE |=> !RELAY_EN && !BRIDGE_EN && !BRAKE_LOCK)
        else $error("drive enabled during alarm");
    a_alarm_latch: assert property (@(posedge CLOCK) disable iff (!RSTN)
        r.alarm[AL_FEEDBACK] && !clear_ev |=> r.alarm[AL_FEEDBACK])
        else $error("alarm flag lost");
    a_safety_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
        CE && !COND.safety_ok |=> r.alarm[AL_SAFETY])
        else $error("safety alarm missing");
    a_overv_set: assert property (@(posedge CLOCK) disable iff (!RSTN)
        CE && COND.bus_volt > OVERV_HIGH_V |=> r.alarm[AL_OVERV])
        else $error("overvoltage missed");
    a_underv_set: assert property (@(posedge CLOCK) disable iff (!RSTN)
        CE && COND.bus_volt < UNDERV_V |=> r.alarm[AL_OTHER])
        else $error("undervoltage missed");
    a_reversal_sticky: assert property (@(posedge CLOCK) disable iff (!RSTN)
        REVERSAL |=> REVERSAL) else $error("reversal flag dropped");
    a_travel_stop: assert property (@(posedge CLOCK) disable iff (!RSTN)
        CE && COND.cw_limit |=> CLOCKWISE_TRAVEL_LIMIT && !RELAY_EN)
        else $error("overtravel not stopping");
    a_overcur_set: assert property (@(posedge CLOCK) disable iff (!RSTN)
        CE && |COND.phase_overcur |=> r.alarm[AL_OVERCUR])
        else $error("overcurrent missed");

endmodule

// ---- dasup_plant.sv ----
// Partner model: power stage and sensors around the supervisor
`timescale 1ns/1ps
module dasup_plant
    import dasup_pkg::*;
(
    // Requested conditions and drive enables
    input wire dasup_cond_t req,
    input wire logic relay_en,
    input wire logic bridge_en,
    // Conditions seen by the supervisor
    output dasup_cond_t cond
);
    always_comb
    begin
        cond = req;
        // Motor only turns while both power paths are enabled
        cond.motor_running = req.motor_running & relay_en & bridge_en;
        cond.speed = cond.motor_running ? req.setpoint : 16'h0000;
    end
endmodule

// ---- test_drive_alarm_supervisor.sv ----
// Self-checking testbench of the drive alarm supervisor
`timescale 1ns/1ps
module test_drive_alarm_supervisor
    import dasup_pkg::*;
;
    typedef struct packed {logic [31:0] data; logic err; logic chk;} dasup_note_t;
    dasup_note_t notes[$];
    dasup_note_t note;
    logic clock, rstn, psel, penable, pwrite, pready, pslverr;
    logic relay_en, bridge_en, brake_lock, reversal, cw_lim, ccw_lim;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] led, relay_stat, brake_stat;
    logic [AL_N-1:0] alarm;
    logic ce;
    dasup_cond_t req, cond;
    int error_cnt = 0;
    int tests_run = 0;
    int seed = 96412;
    int al_bit [0:21] = '{AL_DRVTEMP, AL_FEEDBACK, AL_OVERCUR, AL_EMERG, AL_OVERV, AL_OTHER,
        AL_MOTTEMP, AL_SAFETY, -1, -1, -1, -1, AL_CONFIG, AL_ANALOG, AL_COMM, AL_MOTTEMP,
        -1, AL_OVERV, AL_SETPT, AL_CONFIG, AL_EMERG, -1};
    logic [31:0] ctl [0:21] = '{32'h405, 32'h405, 32'h405, 32'h405, 32'h405, 32'h405,
        32'h405, 32'h405, 32'h405, 32'h405, 32'h405, 32'h405, 32'h405, 32'h401, 32'h406,
        32'h415, 32'h40d, 32'h40d, 32'h401, 32'h305, 32'h401, 32'h404};
    logic [31:0] rcfg [0:4] = '{32'h401, 32'h402, 32'h403, 32'h405, 32'h404};

    dasup_top u_dut (.CLOCK(clock), .RSTN(rstn), .CE(ce), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(pslverr), .COND(cond), .RELAY_EN(relay_en), .BRIDGE_EN(bridge_en),
        .BRAKE_LOCK(brake_lock), .LED(led), .RELAY_STAT(relay_stat), .BRAKE_STAT(brake_stat),
        .REVERSAL(reversal), .CLOCKWISE_TRAVEL_LIMIT(cw_lim),
        .COUNTERCLOCKWISE_TRAVEL_LIMIT(ccw_lim), .ALARM(alarm));
    dasup_plant u_plant (.req(req), .relay_en(relay_en), .bridge_en(bridge_en), .cond(cond));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk_port(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic chk_read(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask

    // Safe condition levels with random in-range measurements
    function automatic dasup_cond_t base_cond();
        dasup_cond_t b;
        logic [31:0] r;
        r = $random(seed);
        b = '0;
        b.speed_valid = 1'b1;
        b.drive_temp = 8'h14 + {3'h0, r[4:0]};
        b.motor_temp = 8'h14 + {3'h0, r[12:8]};
        b.bus_volt = 8'h14 + {3'h0, r[20:16]};
        b.emergency_ok = 1'b1;
        b.safety_ok = 1'b1;
        b.nvm_programmed = 1'b1;
        return b;
    endfunction

    task automatic tick(input int k);
        repeat (k) @(posedge clock);
    endtask

    // One APB transfer; the expected answer is noted first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] x, input logic er, input logic ck);
        notes.push_back('{x, er, ck});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock iff pready);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic er);
        apb(1'b0, a, 32'h0, x, er, 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic er);
        apb(1'b1, a, d, 32'h0, er, 1'b0);
    endtask

    // Shutdown outputs and indicator for alarm or healthy state
    task automatic look(input logic al, input logic run);
        @(negedge clock);
        chk_port("RELAY_EN", 32'(!al), 32'(relay_en));
        chk_port("BRIDGE_EN", 32'(!al), 32'(bridge_en));
        chk_port("RELAY_STAT", al ? 32'(RELAY_DISABLED) : 32'(RELAY_ENABLED), 32'(relay_stat));
        chk_port("BRAKE_STAT", 32'(BRAKE_UNLOCKED), 32'(brake_stat));
        if (al)
            chk_port("LED", 32'(LED_RED), 32'(led));
        else
            chk_port("LED blink", 32'h1, 32'(led === (run ? LED_GREEN : LED_ORANGE) || led === LED_OFF));
        @(posedge clock);
    endtask

    task automatic cause(input int k);
        case (k)
            0: req.drive_temp <= 8'h51;
            1: req.feedback_fault <= 1'b1;
            2: req.phase_overcur <= 3'b010;
            3, 20, 21: req.emergency_ok <= 1'b0;
            4: req.bus_volt <= 8'd81;
            5: req.bus_volt <= 8'd11;
            6: req.motor_temp <= 8'h51;
            7: req.safety_ok <= 1'b0;
            8, 14: req.comm_timeout <= 1'b1;
            9, 13: req.analog_open <= 1'b1;
            10: req.bus_volt <= 8'd80;
            11: req.bus_volt <= 8'd12;
            12: req.nvm_programmed <= 1'b0;
            15: req.motor_sensor_open <= 1'b1;
            16: req.bus_volt <= 8'd122;
            17: req.bus_volt <= 8'd123;
            18: req.pot_nonzero <= 1'b1;
            default: ;
        endcase
    endtask

    // Every read answer is compared against the oldest note
    always @(posedge clock)
    begin
        if (pready === 1'b1)
        begin
            note = notes.pop_front();
            chk_read("PSLVERR", 32'(note.err), 32'(pslverr));
            if (note.chk)
                chk_read("PRDATA", note.data, prdata);
        end
    end

    initial
    begin
        #750000;
        error_cnt++;
        complete_run();
    end

    initial
    begin
        rstn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        req = base_cond();
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        rd(OFF_CTRL, CTRL_RESET, 1'b0);
        rd(OFF_FOLLOW, {16'h0, FOLLOW_RESET}, 1'b0);
        rd(OFF_TEMP, {16'h0, TEMP_RESET, TEMP_RESET}, 1'b0);
        rd(OFF_ALARM, 32'(1) << AL_CONFIG, 1'b0);
        rd(8'h20, 32'h0, 1'b1);
        wr(8'h24, 32'h1, 1'b1);
        for (int k = 0; k < 22; k++)
        begin
            req <= base_cond();
            wr(OFF_CTRL, ctl[k], 1'b0);
            wr(OFF_CTRL, ctl[k] | 32'h20, 1'b0);
            cause(k);
            tick(4);
            req <= base_cond();
            tick(2);
            look(al_bit[k] >= 0, 1'b0);
            rd(OFF_ALARM, al_bit[k] >= 0 ? 32'(1) << al_bit[k] : 32'h0, 1'b0);
        end
        for (int i = 0; i < 5; i++)
        begin
            req <= base_cond();
            wr(OFF_CTRL, rcfg[i] | 32'h20, 1'b0);
            req.feedback_fault <= 1'b1;
            tick(3);
            req <= base_cond();
            tick(2);
            if (i == 4)
                req.can_fault_reset <= 1'b1;
            else
                req.reset_pin <= 1'b1;
            tick(1);
            req.can_fault_reset <= 1'b0;
            tick(3);
            rd(OFF_ALARM, i == 3 ? 32'(1) << AL_FEEDBACK : 32'h0, 1'b0);
        end
        req <= base_cond();
        req.can_switch_on_disabled <= 1'b1;
        wr(OFF_CTRL, 32'h424, 1'b0);
        req.feedback_fault <= 1'b1;
        tick(4);
        @(negedge clock);
        chk_port("LED", 32'(LED_ORANGE), 32'(led));
        chk_port("RELAY_EN", 32'h0, 32'(relay_en));
        @(posedge clock);
        wr(OFF_CTRL, 32'h444, 1'b0);
        tick(3);
        look(1'b1, 1'b0);
        req <= base_cond();
        wr(OFF_CTRL, 32'h425, 1'b0);
        rd(OFF_CTRL, 32'h405, 1'b0);
        req.relay_fault <= 1'b1;
        req.brake_fault <= 1'b1;
        req.supply_reversed <= 1'b1;
        req.cw_limit <= 1'b1;
        tick(4);
        @(negedge clock);
        chk_port("RELAY_STAT", 32'(RELAY_FAILED), 32'(relay_stat));
        chk_port("BRAKE_STAT", 32'(BRAKE_FAILED), 32'(brake_stat));
        chk_port("CW", 32'h1, 32'(cw_lim));
        chk_port("CCW", 32'h0, 32'(ccw_lim));
        chk_port("BRIDGE_EN", 32'h0, 32'(bridge_en));
        @(posedge clock);
        req <= base_cond();
        req.ccw_limit <= 1'b1;
        tick(4);
        @(negedge clock);
        chk_port("CCW", 32'h1, 32'(ccw_lim));
        chk_port("CW", 32'h0, 32'(cw_lim));
        chk_port("RELAY_EN", 32'h0, 32'(relay_en));
        @(posedge clock);
        req <= base_cond();
        wr(OFF_CTRL, 32'h425, 1'b0);
        req.motor_running <= 1'b1;
        tick(4);
        chk_port("REVERSAL", 32'h1, 32'(reversal));
        look(1'b0, 1'b1);
        req.feedback_fault <= 1'b1;
        tick(4);
        look(1'b1, 1'b1);
        // Clock enable low freezes the alarm latch
        ce <= 1'b0;
        req.safety_ok <= 1'b0;
        tick(3);
        @(negedge clock);
        chk_port("ALARM frozen", 32'(1) << AL_FEEDBACK, 32'(alarm));
        @(posedge clock);
        ce <= 1'b1;
        tick(2);
        @(negedge clock);
        chk_port("ALARM", (32'(1) << AL_FEEDBACK) | (32'(1) << AL_SAFETY), 32'(alarm));
        @(posedge clock);
        complete_run();
    end
endmodule
